// ### pmrs_defs.svh
// Constants for the pump run sequencer: offsets, fields, resets, thresholds
//
// Operation
// - Mode-select press toggles panel/external control; external lamp lit only in external.
// - External mode runs from external inputs; panel mode from panel start/stop.
// - Panel start enters accelerating, shows accelerating display, lights rotating lamp.
// - External start raises accelerating and rotating status outputs.
// - At 80% rated speed on start, at-speed lamp lights, display shows at-speed.
// - At 80% threshold accelerating output drops and at-speed output rises.
// - Panel stop enters braking, display shows braking, at-speed lamp goes dark.
// - Host asserts stop input; device shows braking output while decelerating.
// - End of braking drops rotating and braking together; display shows stopped.
// - Rotating outputs clear once measured speed is at or below 60 rpm.
// - Speed mode rated/reduced comes from panel setting or external select input.
// - Speed mode change accepted whether stopped, accelerating or running.
// - Reduced target settable 25 % to 100 % of rated in 0.1 % steps.
// - Changed reduced target while running makes speed move to and hold it.
// - Mode transitions use the same ramp rate as normal start and stop.
// - Reduced start: at-speed rises at 80 % of reduced target, then holds.
// - Rated to lower reduced speed: at-speed drops, braking rises until reached.
// - Back to rated: accelerating shown only if reduced target was at most 80 %.
`ifndef PMRS_DEFS_SVH
`define PMRS_DEFS_SVH

// Register byte offsets
`define PMRS_CTRL_OFS    4'h0
`define PMRS_REDUCED_OFS 4'h4
`define PMRS_STATUS_OFS  4'h8
`define PMRS_SPEED_OFS   4'hC

// Control and status fields
`define PMRS_CTRL_RED_BIT   0
`define PMRS_ST_EXT_BIT     3
`define PMRS_ST_RED_BIT     4
`define PMRS_ST_RISE_BIT    5
`define PMRS_ST_ATSPD_BIT   6
`define PMRS_ST_SLOW_BIT    7
`define PMRS_ST_ROT_BIT     8

// Reduced target in tenths of a percent
`define PMRS_RED_MIN   10'h0FA
`define PMRS_RED_MAX   10'h3E8
`define PMRS_RED_RST   10'h1F4
`define PMRS_PERMILLE  26'h000_03E8

// Speed thresholds
`define PMRS_AT_SPEED_PCT 20'h0_0050
`define PMRS_PCT_DIV      20'h0_0064
`define PMRS_STILL_RPM    16'h003C

`endif

// ### pmrs_host_model.sv
// Host equipment model: remote-control lines and a rotor that follows the command
`timescale 1ns/100ps
module pmrs_host_model (
    // Clock and drive command
    input  wire logic        ref_clk,
    input  wire logic [15:0] cmdSpeed,
    // Remote-control lines
    output logic             extStart,
    output logic             extStop,
    output logic             extReducedSel,
    // Rotor speed feedback
    output logic      [15:0] measSpeed
);
    initial begin
        extStart      = 1'b0;
        extStop       = 1'b0;
        extReducedSel = 1'b0;
        measSpeed     = 16'h0000;
    end
    // Rotor lags the command by one cycle, so thresholds are crossed after the command
    always @(posedge ref_clk) begin
        measSpeed <= cmdSpeed;
    end
    // Start and stop are short pulses; holding a level would not repeat a command
    task automatic pulse(input bit stopCmd);
        @(posedge ref_clk);
        if (stopCmd) extStop <= 1'b1;
        else extStart <= 1'b1;
        @(posedge ref_clk);
        extStart <= 1'b0;
        extStop  <= 1'b0;
    endtask
    task automatic set_low(input logic v);
        @(posedge ref_clk);
        extReducedSel <= v;
    endtask
endmodule

// ### pmrs_pkg.sv
// Types shared by the pump run sequencer modules
package pmrs_pkg;

    typedef enum logic [2:0] {
        ST_STOP  = 3'b000,
        ST_ACC   = 3'b001,
        ST_NORM  = 3'b010,
        ST_SLOW  = 3'b011,
        ST_SLOWING_STATUS = 3'b100
    } pmrs_state_e;

    typedef enum logic [1:0] {
        DSP_STOP  = 2'b00,
        DSP_ACC   = 2'b01,
        DSP_NORM  = 2'b10,
        DSP_SLOWING_STATUS = 2'b11
    } pmrs_disp_e;

    typedef struct packed {
        pmrs_state_e state;
        logic        extMode;
        logic        modePrev;
        logic        startPrev;
        logic        stopPrev;
        logic        xStartPrev;
        logic        xStopPrev;
        logic        panelReduced;
        logic [9:0]  reducedPm;
        logic [15:0] targetPrev;
        logic        rising;
        logic        atSpeed;
        logic        slowing;
        logic        rotating;
        pmrs_disp_e  disp;
        logic        waitReq;
        logic [31:0] rdata;
    } pmrs_top_s;

    typedef struct packed {
        logic [15:0] divCnt;
        logic [15:0] speed;
    } pmrs_ramp_s;

endpackage

// ### pmrs_run_monitor.sv
// Concurrent checks on the run sequencer top-level ports
`timescale 1ns/100ps
module pmrs_run_monitor #(
    parameter logic [15:0] RATED_RPM = 16'h7530
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Commands and speed
    input wire logic        modeSelBtn,
    input wire logic        panelStartBtn,
    input wire logic        panelStopBtn,
    input wire logic        extStart,
    input wire logic        extStop,
    input wire logic        extReducedSel,
    input wire logic [15:0] measSpeed,
    // Status lines
    input wire logic        speedRisingIndication,
    input wire logic        atSpeedStatus,
    input wire logic        slowingStatus,
    input wire logic        rotatingStatus,
    input wire logic        extModeLamp,
    input wire logic [1:0]  opDisplay
);
    localparam int AT_RATED = int'(RATED_RPM) * 80 / 100;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    a_one_hot: assert property ($onehot0({speedRisingIndication, atSpeedStatus, slowingStatus}))
        else $error("status outputs overlap");
    a_mode_toggle: assert property ($rose(modeSelBtn) |=> extModeLamp != $past(extModeLamp))
        else $error("mode press did not toggle lamp");
    a_panel_start: assert property (!extModeLamp && $rose(panelStartBtn) && opDisplay == 2'h0
        && !$rose(modeSelBtn) |=> speedRisingIndication && rotatingStatus && opDisplay == 2'h1)
        else $error("panel start not accelerating");
    a_ext_start: assert property (extModeLamp && $rose(extStart) && opDisplay == 2'h0
        && !$rose(modeSelBtn) |=> speedRisingIndication && rotatingStatus)
        else $error("external start not accelerating");
    a_other_src: assert property (extModeLamp && $rose(panelStartBtn) && !$rose(extStart)
        && !$rose(modeSelBtn) && opDisplay == 2'h0 |=> opDisplay == 2'h0)
        else $error("unselected source started rotor");
    a_panel_stop: assert property (!extModeLamp && $rose(panelStopBtn) && opDisplay == 2'h2
        && !$rose(modeSelBtn) |=> slowingStatus && !atSpeedStatus && opDisplay == 2'h3)
        else $error("panel stop not braking");
    a_ext_stop: assert property (extModeLamp && $rose(extStop) && atSpeedStatus
        && !$rose(modeSelBtn) |=> slowingStatus && !atSpeedStatus)
        else $error("external stop not braking");
    a_rated_at: assert property (extModeLamp && !extReducedSel && $stable(extReducedSel)
        && opDisplay == 2'h1 && measSpeed >= AT_RATED && !$rose(extStop) && !$rose(modeSelBtn)
        |=> atSpeedStatus && !speedRisingIndication)
        else $error("at-speed threshold missed");
    a_stop_done: assert property (opDisplay == 2'h3 && measSpeed <= 16'h003C
        && !$rose(panelStartBtn) && !$rose(extStart) |=> !rotatingStatus && !slowingStatus && opDisplay == 2'h0)
        else $error("braking did not finish");
    a_rot_drop: assert property ($fell(rotatingStatus) |-> $past(measSpeed) <= 16'h003C)
        else $error("rotating dropped above still speed");
    c_at_speed: cover property ($rose(atSpeedStatus));
    c_stopped: cover property ($fell(rotatingStatus));
    c_ext_mode: cover property ($rose(extModeLamp));
endmodule

bind pmrs_run_sequencer pmrs_run_monitor #(.RATED_RPM(RATED_RPM)) mon_u (.ref_clk(ref_clk), .rst(rst),
    .modeSelBtn(modeSelBtn), .panelStartBtn(panelStartBtn), .panelStopBtn(panelStopBtn),
    .extStart(extStart), .extStop(extStop), .extReducedSel(extReducedSel), .measSpeed(measSpeed),
    .speedRisingIndication(speedRisingIndication), .atSpeedStatus(atSpeedStatus),
    .slowingStatus(slowingStatus), .rotatingStatus(rotatingStatus), .extModeLamp(extModeLamp),
    .opDisplay(opDisplay));

// ### pmrs_run_sequencer.sv
// Run-state sequencer top: control source, run states, status lines, registers
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pmrs_defs.svh"
module pmrs_run_sequencer #(
    parameter logic [15:0] RATED_RPM = 16'h7530,
    parameter logic [15:0] STEP_RPM  = 16'h000A,
    parameter logic [15:0] DIV_CYC   = 16'h03E8
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,

    // Avalon-MM register slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,

    // Front panel switches
    input  wire logic        modeSelBtn,
    input  wire logic        panelStartBtn,
    input  wire logic        panelStopBtn,

    // External control inputs
    input  wire logic        extStart,
    input  wire logic        extStop,
    input  wire logic        extReducedSel,

    // Measured rotor speed in rpm
    input  wire logic [15:0] measSpeed,

    // Status lines and lamps
    output logic             speedRisingIndication,
    output logic             atSpeedStatus,
    output logic             slowingStatus,
    output logic             rotatingStatus,
    output logic             extModeLamp,
    output logic      [1:0]  opDisplay,

    // Speed command to the drive
    output logic      [15:0] cmdSpeed
);

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers

    function automatic logic [15:0] pct80(input logic [15:0] spd);
        logic [23:0] prod;
        prod  = {8'h00, spd} * 24'(`PMRS_AT_SPEED_PCT);
        pct80 = 16'(prod / 24'(`PMRS_PCT_DIV));
    endfunction

    function automatic logic [15:0] scaleRated(input logic [9:0] pm);
        logic [25:0] prod;
        prod       = {10'h000, RATED_RPM} * {16'h0000, pm};
        scaleRated = 16'(prod / `PMRS_PERMILLE);
    endfunction

    function automatic logic [9:0] clampPm(input logic [9:0] pm);
        if (pm < `PMRS_RED_MIN) begin
            clampPm = `PMRS_RED_MIN;
        end else if (pm > `PMRS_RED_MAX) begin
            clampPm = `PMRS_RED_MAX;
        end else begin
            clampPm = pm;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    pmrs_pkg::pmrs_top_s r_reg;
    pmrs_pkg::pmrs_top_s r_next;

    logic        modeEv;
    logic        startCmd;
    logic        stopCmd;
    logic        reducedSel;
    logic [15:0] target;
    logic        targetChg;
    logic [15:0] goalSpeed;
    logic        busReq;
    logic        wrTake;
    logic [15:0] wrMask;
    logic [15:0] redMerged;

    // Only the selected source's commands reach the state machine
    assign modeEv   = modeSelBtn & ~r_reg.modePrev;
    assign startCmd = r_reg.extMode ? (extStart & ~r_reg.xStartPrev)
                                    : (panelStartBtn & ~r_reg.startPrev);
    assign stopCmd  = r_reg.extMode ? (extStop & ~r_reg.xStopPrev)
                                    : (panelStopBtn & ~r_reg.stopPrev);

    // Speed mode may change in any state; the target follows at once
    assign reducedSel = r_reg.extMode ? extReducedSel : r_reg.panelReduced;
    assign target     = reducedSel ? scaleRated(r_reg.reducedPm) : RATED_RPM;
    assign targetChg  = (target != r_reg.targetPrev);

    assign goalSpeed = (r_reg.state == pmrs_pkg::ST_SLOWING_STATUS ||
                        r_reg.state == pmrs_pkg::ST_STOP) ? 16'h0000 : target;

    assign busReq    = avs_read | avs_write;
    assign wrTake    = avs_write & ~r_reg.waitReq;
    assign wrMask    = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign redMerged = (avs_writedata[15:0] & wrMask) | ({6'h00, r_reg.reducedPm} & ~wrMask);

    ////////////////////////////////////////////////////////////////////////
    // Speed ramp

    pmrs_speed_ramp #(
        .STEP_RPM (STEP_RPM),
        .DIV_CYC  (DIV_CYC)
    ) u_ramp (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .goalSpeed (goalSpeed),
        .cmdSpeed  (cmdSpeed)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        r_next = r_reg;

        r_next.modePrev   = modeSelBtn;
        r_next.startPrev  = panelStartBtn;
        r_next.stopPrev   = panelStopBtn;
        r_next.xStartPrev = extStart;
        r_next.xStopPrev  = extStop;
        r_next.targetPrev = target;

        if (modeEv) begin
            r_next.extMode = ~r_reg.extMode;
        end

        case (r_reg.state)
            pmrs_pkg::ST_STOP: begin
                if (startCmd) begin
                    r_next.state = pmrs_pkg::ST_ACC;
                end
            end
            pmrs_pkg::ST_ACC: begin
                if (stopCmd) begin
                    r_next.state = pmrs_pkg::ST_SLOWING_STATUS;
                end else if (reducedSel && measSpeed > target) begin
                    r_next.state = pmrs_pkg::ST_SLOW;
                end else if (measSpeed >= pct80(target)) begin
                    r_next.state = pmrs_pkg::ST_NORM;
                end
            end
            pmrs_pkg::ST_NORM: begin
                if (stopCmd) begin
                    r_next.state = pmrs_pkg::ST_SLOWING_STATUS;
                end else if (targetChg && target < measSpeed) begin
                    r_next.state = pmrs_pkg::ST_SLOW;
                end else if (targetChg && target > r_reg.targetPrev &&
                             r_reg.targetPrev <= pct80(target)) begin
                    r_next.state = pmrs_pkg::ST_ACC;
                end
            end
            pmrs_pkg::ST_SLOW: begin
                // Reverting to rated before arrival also lands here
                if (stopCmd) begin
                    r_next.state = pmrs_pkg::ST_SLOWING_STATUS;
                end else if (measSpeed <= target) begin
                    r_next.state = pmrs_pkg::ST_NORM;
                end
            end
            pmrs_pkg::ST_SLOWING_STATUS: begin
                if (startCmd) begin
                    r_next.state = pmrs_pkg::ST_ACC;
                end else if (measSpeed <= `PMRS_STILL_RPM) begin
                    r_next.state = pmrs_pkg::ST_STOP;
                end
            end
            default: begin
                r_next.state = pmrs_pkg::ST_STOP;
            end
        endcase

        // Status lines decode the next state, so rising, at-speed and slowing can never overlap
        r_next.rising   = (r_next.state == pmrs_pkg::ST_ACC);
        r_next.atSpeed  = (r_next.state == pmrs_pkg::ST_NORM);
        r_next.slowing  = (r_next.state == pmrs_pkg::ST_SLOW) ||
                          (r_next.state == pmrs_pkg::ST_SLOWING_STATUS);
        r_next.rotating = (r_next.state != pmrs_pkg::ST_STOP);

        case (r_next.state)
            pmrs_pkg::ST_ACC: begin
                r_next.disp = pmrs_pkg::DSP_ACC;
            end
            pmrs_pkg::ST_NORM: begin
                r_next.disp = pmrs_pkg::DSP_NORM;
            end
            pmrs_pkg::ST_SLOW, pmrs_pkg::ST_SLOWING_STATUS: begin
                r_next.disp = pmrs_pkg::DSP_SLOWING_STATUS;
            end
            default: begin
                r_next.disp = pmrs_pkg::DSP_STOP;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // Register slave: one wait cycle, then the answer

        r_next.waitReq = ~(busReq & r_reg.waitReq);

        if (busReq && r_reg.waitReq) begin
            case (avs_address)
                `PMRS_CTRL_OFS: begin
                    r_next.rdata = {31'h0000_0000, r_reg.panelReduced};
                end
                `PMRS_REDUCED_OFS: begin
                    r_next.rdata = {22'h00_0000, r_reg.reducedPm};
                end
                `PMRS_STATUS_OFS: begin
                    r_next.rdata = 32'h0000_0000;
                    r_next.rdata[2:0] = r_reg.state;
                    r_next.rdata[`PMRS_ST_EXT_BIT]   = r_reg.extMode;
                    r_next.rdata[`PMRS_ST_RED_BIT]   = reducedSel;
                    r_next.rdata[`PMRS_ST_RISE_BIT]  = r_reg.rising;
                    r_next.rdata[`PMRS_ST_ATSPD_BIT] = r_reg.atSpeed;
                    r_next.rdata[`PMRS_ST_SLOW_BIT]  = r_reg.slowing;
                    r_next.rdata[`PMRS_ST_ROT_BIT]   = r_reg.rotating;
                end
                `PMRS_SPEED_OFS: begin
                    r_next.rdata = {cmdSpeed, measSpeed};
                end
                default: begin
                    r_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        if (wrTake) begin
            case (avs_address)
                `PMRS_CTRL_OFS: begin
                    if (avs_byteenable[0]) begin
                        r_next.panelReduced = avs_writedata[`PMRS_CTRL_RED_BIT];
                    end
                end
                `PMRS_REDUCED_OFS: begin
                    // Bits above 9 are dropped, then out-of-range values are pinned to the nearest limit
                    r_next.reducedPm = clampPm(redMerged[9:0]);
                end
                default: begin
                    r_next.reducedPm = r_reg.reducedPm;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r_reg            <= '0;
            r_reg.state      <= pmrs_pkg::ST_STOP;
            r_reg.disp       <= pmrs_pkg::DSP_STOP;
            r_reg.reducedPm  <= `PMRS_RED_RST;
            r_reg.targetPrev <= RATED_RPM;
            r_reg.waitReq    <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_readdata          = r_reg.rdata;
    assign avs_waitrequest       = r_reg.waitReq;
    assign speedRisingIndication = r_reg.rising;
    assign atSpeedStatus         = r_reg.atSpeed;
    assign slowingStatus         = r_reg.slowing;
    assign rotatingStatus        = r_reg.rotating;
    assign extModeLamp           = r_reg.extMode;
    assign opDisplay             = r_reg.disp;

endmodule

// ### pmrs_speed_ramp.sv
// Speed command ramp: moves toward the goal at one fixed rate both ways
`timescale 1ns/100ps
module pmrs_speed_ramp #(
    parameter logic [15:0] STEP_RPM = 16'h000A,
    parameter logic [15:0] DIV_CYC  = 16'h03E8
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Goal and command
    input  wire logic [15:0] goalSpeed,
    output logic      [15:0] cmdSpeed
);

    pmrs_pkg::pmrs_ramp_s r_reg;
    pmrs_pkg::pmrs_ramp_s r_next;
    logic                 tick;

    assign tick     = (r_reg.divCnt == DIV_CYC - 16'h0001);
    assign cmdSpeed = r_reg.speed;

    ////////////////////////////////////////////////////////////////////////
    // One step per divider tick, same size up and down, so a mode change
    // takes as long as the equivalent part of a start or stop
    always_comb begin
        r_next = r_reg;
        r_next.divCnt = tick ? 16'h0000 : r_reg.divCnt + 16'h0001;
        if (tick) begin
            if (r_reg.speed + STEP_RPM <= goalSpeed) begin
                r_next.speed = r_reg.speed + STEP_RPM;
            end else if (r_reg.speed >= goalSpeed + STEP_RPM) begin
                r_next.speed = r_reg.speed - STEP_RPM;
            end else begin
                r_next.speed = goalSpeed;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

endmodule

// ### pmrs_tb.sv
// Self-checking bench for the run sequencer
`timescale 1ns/100ps
`include "pmrs_defs.svh"
module tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        modeSelBtn = 1'b0;
    logic        panelStartBtn = 1'b0;
    logic        panelStopBtn = 1'b0;
    logic        extStart, extStop, extReducedSel;
    logic [15:0] measSpeed, cmdSpeed;
    logic        speedRisingIndication, atSpeedStatus, slowingStatus, rotatingStatus, extModeLamp;
    logic [1:0]  opDisplay;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          n_checks = 0;
    logic [9:0]  wrVal [5] = '{10'h0F9, 10'h0FA, 10'h3E8, 10'h3E9, 10'h1F4};
    logic [9:0]  expVal [5] = '{10'h0FA, 10'h0FA, 10'h3E8, 10'h3E8, 10'h1F4};
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // Small rated speed and fast ramp keep every run short
    pmrs_run_sequencer #(.RATED_RPM(16'h03E8), .DIV_CYC(16'h0002)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .modeSelBtn(modeSelBtn),
        .panelStartBtn(panelStartBtn), .panelStopBtn(panelStopBtn), .extStart(extStart),
        .extStop(extStop), .extReducedSel(extReducedSel), .measSpeed(measSpeed),
        .speedRisingIndication(speedRisingIndication), .atSpeedStatus(atSpeedStatus),
        .slowingStatus(slowingStatus), .rotatingStatus(rotatingStatus), .extModeLamp(extModeLamp),
        .opDisplay(opDisplay), .cmdSpeed(cmdSpeed));
    pmrs_host_model host_u (.ref_clk(ref_clk), .cmdSpeed(cmdSpeed), .extStart(extStart),
        .extStop(extStop), .extReducedSel(extReducedSel), .measSpeed(measSpeed));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic after(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic press(input int k);
        @(posedge ref_clk);
        case (k)
            0: modeSelBtn <= 1'b1;
            1: panelStartBtn <= 1'b1;
            default: panelStopBtn <= 1'b1;
        endcase
        @(posedge ref_clk);
        modeSelBtn    <= 1'b0;
        panelStartBtn <= 1'b0;
        panelStopBtn  <= 1'b0;
    endtask
    // Bounded wait; running out counts as a mismatch
    task automatic wait_for(input bit rot);
        int i;
        for (i = 0; i < 3000; i++) begin
            @(negedge ref_clk);
            if (rot ? rotatingStatus === 1'b0 : atSpeedStatus === 1'b1) break;
        end
        chk("wait", 1'h1, i < 3000);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        after(1);
        chk("lamp", 1'h0, extModeLamp);
        bus_rd(`PMRS_STATUS_OFS, rd);
        chk("status", 32'h0000_0000, rd);
        bus_wr(`PMRS_STATUS_OFS, 32'hFFFF_FFFF);
        bus_rd(`PMRS_STATUS_OFS, rd);
        chk("status ro", 32'h0000_0000, rd);
        bus_rd(4'h2, rd);
        chk("unmapped", 32'h0000_0000, rd);
        for (int i = 0; i < 5; i++) begin
            bus_wr(`PMRS_REDUCED_OFS, {22'h00_0000, wrVal[i]});
            bus_rd(`PMRS_REDUCED_OFS, rd);
            chk("reduced", {22'h00_0000, expVal[i]}, rd);
        end
        // Partial byte enables: low byte only, then control with bit 0 masked
        avs_byteenable <= 4'h1;
        bus_wr(`PMRS_REDUCED_OFS, 32'h0000_0300);
        bus_rd(`PMRS_REDUCED_OFS, rd);
        chk("reduced be", 32'h0000_0100, rd);
        avs_byteenable <= 4'hE;
        bus_wr(`PMRS_CTRL_OFS, 32'h0000_0001);
        bus_rd(`PMRS_CTRL_OFS, rd);
        chk("ctrl be", 32'h0000_0000, rd);
        avs_byteenable <= 4'hF;
        bus_wr(`PMRS_REDUCED_OFS, 32'h0000_01F4);
        // Panel mode run, then slow to the reduced target while running
        host_u.pulse(1'b0);
        after(1);
        chk("ext ignored", 2'h0, opDisplay);
        press(1);
        after(1);
        chk("rise/rot/disp", 4'hD, {rotatingStatus, speedRisingIndication, opDisplay});
        wait_for(1'b0);
        chk("at 80", 1'h1, measSpeed >= 16'h0320);
        chk("disp", 2'h2, opDisplay);
        bus_wr(`PMRS_CTRL_OFS, 32'h0000_0001);
        after(2);
        chk("slow", 2'h2, {slowingStatus, atSpeedStatus});
        wait_for(1'b0);
        chk("reached", 1'h1, measSpeed <= 16'h01F4);
        after(20);
        chk("hold", 16'h01F4, measSpeed);
        bus_rd(`PMRS_SPEED_OFS, rd);
        chk("speed reg", 32'h01F4_01F4, rd);
        press(2);
        after(1);
        chk("slowing_status", 4'hB, {slowingStatus, atSpeedStatus, opDisplay});
        wait_for(1'b1);
        chk("still", 1'h1, measSpeed <= 16'h003C);
        chk("stopped", 3'h0, {slowingStatus, opDisplay});
        bus_wr(`PMRS_CTRL_OFS, 32'h0000_0000);
        // External mode run with reduced select, then back to rated
        press(0);
        after(1);
        chk("lamp", 1'h1, extModeLamp);
        press(1);
        after(1);
        chk("panel ignored", 2'h0, opDisplay);
        host_u.set_low(1'b1);
        bus_rd(`PMRS_STATUS_OFS, rd);
        chk("status ext", 32'h0000_0018, rd);
        host_u.pulse(1'b0);
        after(1);
        chk("ext rise", 2'h3, {rotatingStatus, speedRisingIndication});
        wait_for(1'b0);
        chk("red 80", 1'h1, measSpeed >= 16'h0190 && measSpeed < 16'h01F4);
        after(60);
        chk("red hold", 16'h01F4, measSpeed);
        host_u.set_low(1'b0);
        after(2);
        chk("to rated", 2'h2, {speedRisingIndication, atSpeedStatus});
        wait_for(1'b0);
        chk("rated 80", 2'h1, {speedRisingIndication, measSpeed >= 16'h0320});
        host_u.pulse(1'b1);
        after(1);
        chk("ext slowing_status", 2'h2, {slowingStatus, atSpeedStatus});
        wait_for(1'b1);
        chk("ext stopped", 4'h0, {slowingStatus, rotatingStatus, opDisplay});
        press(0);
        after(1);
        chk("lamp", 1'h0, extModeLamp);
        report_and_stop();
    end
endmodule
